// [logic/iib_top.sv]
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "iib_cfg.svh"

module iib_top (
	// clock and reset
	input  wire logic               sys_clk,
	input  wire logic               rst,
	// register port
	input  wire logic [11:0]        addr,
	input  wire logic [15:0]        wdata,
	input  wire logic               wr,
	input  wire logic               rd,
	output logic      [15:0]        rdata,
	// sample stream in, one strobe per 304 kHz sample
	input  wire logic               sample_en,
	input  wire logic signed [15:0] first_decimation_filter_out,
	input  wire logic        [7:0]  level_in,
	// muted stream out
	output logic signed [15:0]      mpx_out,
	output logic                    mpx_out_valid,
	output logic                    mute,
	output logic                    flag_output_pin_two
);

	function automatic logic [16:0] iib_mag(input logic signed [16:0] v);
		iib_mag = v[16] ? 17'(-v) : 17'(v);
	endfunction

	logic [15:0] ctrl_reg;
	logic [15:0] dyn_reg;
	logic [15:0] mpx_cfg;
	logic [15:0] lvl_cfg;

	// register writes
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl_reg <= `IIB_CTRL_RESET;
			dyn_reg  <= `IIB_DYN_RESET;
			mpx_cfg  <= `IIB_MPX_RESET;
			lvl_cfg  <= `IIB_LVL_RESET;
		end else if (wr) begin
			case (addr)
				`IIB_ADDR_CTRL: ctrl_reg <= wdata & `IIB_CTRL_MASK;
				`IIB_ADDR_DYN:  dyn_reg  <= wdata;
				`IIB_ADDR_MPX:  mpx_cfg  <= wdata & `IIB_MPX_MASK;
				`IIB_ADDR_LVL:  lvl_cfg  <= wdata & `IIB_LVL_MASK;
				default: ;
			endcase
		end
	end

	logic       mpx_en;
	logic       lvl_en;
	logic       observe;
	logic       am_mode;
	logic [2:0] mpx_thr;
	logic [2:0] mpx_ff;
	logic [2:0] mpx_stretch;
	logic [1:0] mpx_dly_sel;
	logic       agc_shift;
	logic [3:0] lvl_thr;
	logic [1:0] lvl_ff;
	logic [1:0] lvl_stretch;
	logic       dyn_en;
	logic [7:0] dyn_thr1;
	logic [7:0] dyn_thr2;

	assign mpx_en      = ctrl_reg[`IIB_CTRL_MPX_EN];
	assign lvl_en      = ctrl_reg[`IIB_CTRL_LVL_EN];
	assign observe     = ctrl_reg[`IIB_CTRL_OBSERVE];
	assign am_mode     = ctrl_reg[`IIB_CTRL_AM_MODE];
	assign mpx_thr     = mpx_cfg[`IIB_MPX_THR_LSB +: 3];
	assign mpx_ff      = mpx_cfg[`IIB_MPX_FF_LSB +: 3];
	assign mpx_stretch = mpx_cfg[`IIB_MPX_STR_LSB +: 3];
	assign mpx_dly_sel = mpx_cfg[`IIB_MPX_DLY_LSB +: 2];
	assign agc_shift   = mpx_cfg[`IIB_MPX_AGC];
	assign lvl_thr     = lvl_cfg[`IIB_LVL_THR_LSB +: 4];
	assign lvl_ff      = lvl_cfg[`IIB_LVL_FF_LSB +: 2];
	assign lvl_stretch = lvl_cfg[`IIB_LVL_STR_LSB +: 2];
	assign dyn_en      = lvl_cfg[`IIB_LVL_DYN_EN];
	assign dyn_thr1    = dyn_reg[`IIB_DYN_THR1_LSB +: 8];
	assign dyn_thr2    = dyn_reg[`IIB_DYN_THR2_LSB +: 8];

	// multiplex detector: first difference as the high-pass branch
	logic signed [15:0] mpx_prev;
	logic        [16:0] hp_mag;
	logic        [16:0] abs_x;
	logic        [3:0]  thr_p1;
	logic        [16:0] thr_base;
	logic        [16:0] ff_term;
	logic        [17:0] mpx_limit;
	logic               mpx_trig_now;

	always_ff @(posedge sys_clk) begin
		if (rst)
			mpx_prev <= 16'sh0000;
		else if (sample_en)
			mpx_prev <= first_decimation_filter_out;
	end

	assign hp_mag = iib_mag(17'({first_decimation_filter_out[15],
		first_decimation_filter_out} - {mpx_prev[15], mpx_prev}));
	assign abs_x  = iib_mag({first_decimation_filter_out[15],
		first_decimation_filter_out});
	assign thr_p1 = {1'b0, mpx_thr} + 4'h1;
	// the higher set point doubles every threshold step
	assign thr_base = agc_shift ? {4'h0, thr_p1, 9'h000}
		: {5'h00, thr_p1, 8'h00};
	assign ff_term = (mpx_ff == 3'h0) ? 17'h00000
		: abs_x >> (4'h8 - {1'b0, mpx_ff});
	assign mpx_limit = {1'b0, thr_base} + {1'b0, ff_term};
	assign mpx_trig_now = ({1'b0, hp_mag} > mpx_limit);

	// multiplex stretch
	logic [2:0] mpx_str_cnt;
	logic       mpx_pulse_now;

	always_ff @(posedge sys_clk) begin
		if (rst)
			mpx_str_cnt <= 3'h0;
		else if (sample_en) begin
			if (mpx_trig_now)
				mpx_str_cnt <= mpx_stretch;
			else if (mpx_str_cnt != 3'h0)
				mpx_str_cnt <= mpx_str_cnt - 3'h1;
		end
	end

	assign mpx_pulse_now = mpx_trig_now | (mpx_str_cnt != 3'h0);

	// multiplex delay line, taps give two to five samples
	logic signed [15:0] mpx_dly [0:4];
	logic signed [15:0] mpx_tap;

	always_ff @(posedge sys_clk) begin
		if (rst)
			mpx_dly[0] <= 16'sh0000;
		else if (sample_en)
			mpx_dly[0] <= first_decimation_filter_out;
	end

	genvar gi;
	generate
		for (gi = 1; gi < 5; gi++) begin : g_dly
			always_ff @(posedge sys_clk) begin
				if (rst)
					mpx_dly[gi] <= 16'sh0000;
				else if (sample_en)
					mpx_dly[gi] <= mpx_dly[gi-1];
			end
		end
	endgenerate

	assign mpx_tap = mpx_dly[3'({1'b0, mpx_dly_sel} + 3'h1)];

	// level detector on rising steps of the level converter output
	logic [7:0] lvl_prev;
	logic [7:0] lvl_rise;
	logic       lvl_trig_now;

	always_ff @(posedge sys_clk) begin
		if (rst)
			lvl_prev <= 8'h00;
		else if (sample_en)
			lvl_prev <= level_in;
	end

	assign lvl_rise = (level_in > lvl_prev) ? 8'(level_in - lvl_prev)
		: 8'h00;
	// AM mode leaves the level pin unused
	assign lvl_trig_now = (lvl_thr != 4'h0) & ~am_mode
		& (lvl_rise > {2'b00, lvl_thr, 2'b00});

	// level alignment; the default tap follows the multiplex delay so the
	// level pulse reaches the switch together with the disturbance
	logic [6:0] lvl_tr;
	logic [2:0] dly_base;
	logic [2:0] lvl_tap;
	logic       lvl_aligned;

	always_ff @(posedge sys_clk) begin
		if (rst)
			lvl_tr <= 7'h00;
		else if (sample_en)
			lvl_tr <= {lvl_tr[5:0], lvl_trig_now};
	end

	assign dly_base = {1'b0, mpx_dly_sel};

	always_comb begin
		case (iib_pkg::iib_lvl_ff_t'(lvl_ff))
			iib_pkg::IIB_FF_ADVANCE: lvl_tap = dly_base;
			iib_pkg::IIB_FF_DELAY1:  lvl_tap = dly_base + 3'h2;
			iib_pkg::IIB_FF_DELAY2:  lvl_tap = dly_base + 3'h3;
			default:                 lvl_tap = dly_base + 3'h1;
		endcase
	end

	assign lvl_aligned = lvl_tr[lvl_tap];

	logic [1:0] lvl_str_cnt;
	logic       lvl_pulse_now;

	always_ff @(posedge sys_clk) begin
		if (rst)
			lvl_str_cnt <= 2'h0;
		else if (sample_en) begin
			if (lvl_aligned)
				lvl_str_cnt <= lvl_stretch;
			else if (lvl_str_cnt != 2'h0)
				lvl_str_cnt <= lvl_str_cnt - 2'h1;
		end
	end

	assign lvl_pulse_now = lvl_aligned | (lvl_str_cnt != 2'h0);

	// dynamic stage: one-pole low-pass, coefficient 1/4 gives ~15 kHz
	logic signed [15:0] mono;
	logic signed [16:0] mono_diff;
	logic        [16:0] mono_mag;
	logic        [7:0]  mono_lvl;
	logic               over1;
	logic               over2;
	logic        [7:0]  dyn_cnt;
	iib_pkg::iib_dyn_state_t dyn_state;
	logic               dyn_active;

	assign mono_diff = 17'({first_decimation_filter_out[15],
		first_decimation_filter_out} - {mono[15], mono});

	always_ff @(posedge sys_clk) begin
		if (rst)
			mono <= 16'sh0000;
		else if (sample_en)
			mono <= 16'(mono + (mono_diff >>> 2));
	end

	assign mono_mag = iib_mag({mono[15], mono});
	assign mono_lvl = mono_mag[16] ? 8'hff : mono_mag[15:8];
	assign over1    = mono_lvl > dyn_thr1;
	assign over2    = {1'b0, mono_lvl} > ({1'b0, dyn_thr1} + {1'b0, dyn_thr2});

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			dyn_state <= iib_pkg::IIB_DYN_IDLE;
			dyn_cnt   <= 8'h00;
		end else if (sample_en) begin
			case (dyn_state)
				iib_pkg::IIB_DYN_IDLE: begin
					dyn_cnt <= 8'h00;
					if (dyn_en && over1)
						dyn_state <= iib_pkg::IIB_DYN_WATCH;
				end
				iib_pkg::IIB_DYN_WATCH: begin
					if (!dyn_en || !over1)
						dyn_state <= iib_pkg::IIB_DYN_IDLE;
					else if (dyn_cnt >= `IIB_DYN_HOLD - 8'h01) begin
						if (over2)
							dyn_state <= iib_pkg::IIB_DYN_SUPPRESS;
					end else
						dyn_cnt <= dyn_cnt + 8'h01;
				end
				iib_pkg::IIB_DYN_SUPPRESS: begin
					if (!dyn_en || !over2)
						dyn_state <= iib_pkg::IIB_DYN_IDLE;
				end
				default: dyn_state <= iib_pkg::IIB_DYN_IDLE;
			endcase
		end
	end

	assign dyn_active = (dyn_state == iib_pkg::IIB_DYN_SUPPRESS);

	// mute switch; either detector alone is enough
	logic next_mute;

	assign next_mute = ~dyn_active & ~am_mode
		& ((mpx_en & mpx_pulse_now) | (lvl_en & lvl_pulse_now));

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mute          <= 1'b0;
			mpx_out       <= 16'sh0000;
			mpx_out_valid <= 1'b0;
		end else begin
			mpx_out_valid <= sample_en;
			if (sample_en) begin
				mute    <= next_mute;
				mpx_out <= next_mute ? 16'sh0000 : mpx_tap;
			end
		end
	end

	// raw trigger is shown unstretched so settings can be judged directly
	always_ff @(posedge sys_clk) begin
		if (rst)
			flag_output_pin_two <= 1'b0;
		else
			flag_output_pin_two <= observe
				& ((mpx_en & mpx_trig_now) | (lvl_en & lvl_trig_now));
	end

	// register reads, unmapped addresses read zero
	always_ff @(posedge sys_clk) begin
		if (rst)
			rdata <= 16'h0000;
		else if (rd) begin
			case (addr)
				`IIB_ADDR_CTRL: rdata <= ctrl_reg;
				`IIB_ADDR_DYN:  rdata <= dyn_reg;
				`IIB_ADDR_MPX:  rdata <= mpx_cfg;
				`IIB_ADDR_LVL:  rdata <= lvl_cfg;
				`IIB_ADDR_STAT: rdata <= {12'h000, mute, dyn_active,
					lvl_pulse_now, mpx_pulse_now};
				default:        rdata <= 16'h0000;
			endcase
		end
	end

	// assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_reset_nominal: assert property ($fell(rst) |->
		mpx_cfg == `IIB_MPX_RESET)
		else $error("multiplex fields not nominal after reset");

	a_cfg_write: assert property ((wr && addr == `IIB_ADDR_MPX) |=>
		mpx_cfg == ($past(wdata) & `IIB_MPX_MASK))
		else $error("multiplex coefficient write lost");

	a_mpx_alone: assert property ((sample_en && mpx_en && mpx_trig_now
		&& !dyn_active && !am_mode) |=> mute)
		else $error("multiplex trigger alone did not mute");

	a_lvl_alone: assert property ((sample_en && lvl_en && lvl_aligned
		&& !dyn_active && !am_mode) |=> mute)
		else $error("level pulse alone did not mute");

	a_mpx_disabled: assert property ((sample_en && !mpx_en
		&& !(lvl_en && lvl_pulse_now)) |=> !mute)
		else $error("disabled detector still muted");

	a_lvl_off_code: assert property ((sample_en && lvl_thr == 4'h0) |=>
		!lvl_tr[0])
		else $error("level detector active with zero threshold");

	a_dyn_blocks: assert property ((sample_en && dyn_active) |=>
		!mute)
		else $error("mute during dynamic suppression");

	a_mute_zero: assert property ((mute && mpx_out_valid) |->
		mpx_out == 16'sh0000)
		else $error("muted sample not zero");

	a_stretch_load: assert property ((sample_en && mpx_trig_now) |=>
		mpx_str_cnt == $past(mpx_stretch))
		else $error("stretch count not loaded");

	a_am_quiet: assert property ((sample_en && am_mode) |=> !mute)
		else $error("mute in AM mode");

	a_observe_off: assert property (!observe |=>
		!flag_output_pin_two)
		else $error("flag pin active without observe");

	c_mute_rise: cover property (sample_en ##1 $rose(mute));
	c_dyn_enter: cover property ($rose(dyn_active));
	c_lvl_mute: cover property (lvl_aligned && !mpx_pulse_now
		&& sample_en ##1 mute);
	c_flag_seen: cover property ($rose(flag_output_pin_two));

endmodule

// [logic/iib_cfg.svh]
`ifndef IIB_CFG_SVH
`define IIB_CFG_SVH

// register addresses
`define IIB_ADDR_CTRL      12'hff0
`define IIB_ADDR_DYN       12'hff1
`define IIB_ADDR_STAT      12'hff2
`define IIB_ADDR_MPX       12'hffb
`define IIB_ADDR_LVL       12'hffc

// reset values and write masks
`define IIB_CTRL_RESET     16'h0003
`define IIB_DYN_RESET      16'h1060
`define IIB_MPX_RESET      16'h0293
`define IIB_LVL_RESET      16'h0046
`define IIB_MPX_MASK       16'h0fff
`define IIB_LVL_MASK       16'h80ff
`define IIB_CTRL_MASK      16'h000f

// control word fields
`define IIB_CTRL_MPX_EN    0
`define IIB_CTRL_LVL_EN    1
`define IIB_CTRL_OBSERVE   2
`define IIB_CTRL_AM_MODE   3

// multiplex detector word fields
`define IIB_MPX_THR_LSB    0
`define IIB_MPX_FF_LSB     3
`define IIB_MPX_STR_LSB    6
`define IIB_MPX_DLY_LSB    9
`define IIB_MPX_AGC        11

// level detector word fields
`define IIB_LVL_THR_LSB    0
`define IIB_LVL_FF_LSB     4
`define IIB_LVL_STR_LSB    6
`define IIB_LVL_DYN_EN     15

// dynamic stage thresholds
`define IIB_DYN_THR1_LSB   0
`define IIB_DYN_THR2_LSB   8

// samples the mono level must stay above the first threshold
`define IIB_DYN_HOLD       8'd16

`endif

// [logic/iib_pkg.sv]
package iib_pkg;

	typedef enum logic [1:0] {
		IIB_FF_DEFAULT = 2'b00,
		IIB_FF_ADVANCE = 2'b01,
		IIB_FF_DELAY1  = 2'b10,
		IIB_FF_DELAY2  = 2'b11
	} iib_lvl_ff_t;

	typedef enum logic [1:0] {
		IIB_DYN_IDLE     = 2'b00,
		IIB_DYN_WATCH    = 2'b01,
		IIB_DYN_SUPPRESS = 2'b10
	} iib_dyn_state_t;

endpackage

// [testbench/iib_src_model.sv]
`timescale 1ns/1ps
module iib_src_model #(
	parameter int PERIOD = 6
) (
	// clock and reset
	input  wire logic               sys_clk,
	input  wire logic               rst,
	// values for the next sample
	input  wire logic signed [15:0] nxt_mpx,
	input  wire logic        [7:0]  nxt_lvl,
	// stream toward the blanker
	output logic                    sample_en,
	output logic signed [15:0]      first_decimation_filter_out,
	output logic        [7:0]       level_in
);
	int cnt;

	// real rate is one sample per ~822 clocks; shortened to keep runs brief
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cnt <= 0;
			sample_en <= 1'b0;
			first_decimation_filter_out <= 16'h0000;
			level_in <= 8'h00;
		end else if (cnt == PERIOD - 1) begin
			cnt <= 0;
			sample_en <= 1'b1;
			first_decimation_filter_out <= nxt_mpx;
			level_in <= nxt_lvl;
		end else begin
			cnt <= cnt + 1;
			sample_en <= 1'b0;
			// data only holds in the strobe cycle; toggle so stale use shows
			first_decimation_filter_out <= ~first_decimation_filter_out;
			level_in <= ~level_in;
		end
	end
endmodule

// [testbench/ignition_interference_blanker_bench.sv]
`timescale 1ns/1ps
`include "iib_cfg.svh"
module ignition_interference_blanker_bench;
	logic               sys_clk;
	logic               rst;
	logic        [11:0] addr;
	logic        [15:0] wdata;
	logic               wr;
	logic               rd;
	logic        [15:0] rdata;
	logic               sample_en;
	logic signed [15:0] mpx_in;
	logic        [7:0]  lvl_in;
	logic signed [15:0] nxt_mpx;
	logic        [7:0]  nxt_lvl;
	logic signed [15:0] mpx_out;
	logic               out_valid;
	logic               mute;
	logic               flag;
	logic        [15:0] hist [16];
	int                 miscompares;
	int                 compares;
	int                 cycles;
	int                 tests;
	int                 n_flag;

	iib_top u_iib_top (
		.sys_clk                     (sys_clk),
		.rst                         (rst),
		.addr                        (addr),
		.wdata                       (wdata),
		.wr                          (wr),
		.rd                          (rd),
		.rdata                       (rdata),
		.sample_en                   (sample_en),
		.first_decimation_filter_out (mpx_in),
		.level_in                    (lvl_in),
		.mpx_out                     (mpx_out),
		.mpx_out_valid               (out_valid),
		.mute                        (mute),
		.flag_output_pin_two         (flag)
	);

	iib_src_model u_iib_src_model (
		.sys_clk                     (sys_clk),
		.rst                         (rst),
		.nxt_mpx                     (nxt_mpx),
		.nxt_lvl                     (nxt_lvl),
		.sample_en                   (sample_en),
		.first_decimation_filter_out (mpx_in),
		.level_in                    (lvl_in)
	);

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic give_verdict;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// about 9500 cycles expected; a hang is cut well after that
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			give_verdict();
		end
	end

	task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: word %h wanted %h", $time, g, e);
		end
	endtask

	task automatic chk_cnt(input int g, input int e);
		compares++;
		if (g != e) begin
			miscompares++;
			$display("unexpected at %0t: count %0d wanted %0d", $time, g, e);
		end
	endtask

	task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		rd <= 1'b0;
		@(posedge sys_clk);
		chk_word(rdata, e);
	endtask

	// one sample in, then the answer of the next strobe out
	task automatic feed(input logic [15:0] m, input logic [7:0] l,
			output logic mu, output logic [15:0] o);
		int i;
		nxt_mpx <= m;
		nxt_lvl <= l;
		i = 0;
		do begin
			@(posedge sys_clk);
			i++;
		end while (out_valid !== 1'b1 && i < 100);
		mu = mute;
		o = mpx_out;
		if (flag === 1'b1)
			n_flag++;
	endtask

	// flush at base b with blanking off, then step to v and lv at index 4
	task automatic run_case(input logic [15:0] ctl, mw, lw, b, v,
			input logic [7:0] lv, input int em, ef, eg);
		logic        mu;
		logic [15:0] o;
		int          n_mute;
		int          first;
		wr_reg(`IIB_ADDR_MPX, mw);
		wr_reg(`IIB_ADDR_LVL, lw);
		wr_reg(`IIB_ADDR_CTRL, 16'h0000);
		for (int k = 0; k < 44; k++)
			feed(b, 8'h00, mu, o);
		wr_reg(`IIB_ADDR_CTRL, ctl);
		n_mute = 0;
		n_flag = 0;
		first = -1;
		for (int k = 0; k < 20; k++) begin
			feed(k < 4 ? b : v, k < 4 ? 8'h00 : lv, mu, o);
			if (mu === 1'b1) begin
				n_mute++;
				if (first < 0)
					first = k;
				chk_word(o, 16'h0000);
			end
		end
		chk_cnt(n_mute, em);
		if (ef >= 0)
			chk_cnt(first, ef);
		chk_cnt(n_flag, eg);
		tests++;
		$display("test %0d done", tests);
	endtask

	initial begin
		logic        mu;
		logic [15:0] o;
		rst = 1'b1;
		addr = 12'h000;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		nxt_mpx = 16'h0000;
		nxt_lvl = 8'h00;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		rd_chk(`IIB_ADDR_CTRL, 16'h0003);
		rd_chk(`IIB_ADDR_MPX, 16'h0293);
		rd_chk(`IIB_ADDR_LVL, 16'h0046);
		rd_chk(`IIB_ADDR_DYN, 16'h1060);
		rd_chk(`IIB_ADDR_STAT, 16'h0000);
		rd_chk(12'h123, 16'h0000);
		wr_reg(`IIB_ADDR_MPX, 16'hffff);
		wr_reg(`IIB_ADDR_LVL, 16'hffff);
		wr_reg(`IIB_ADDR_CTRL, 16'hffff);
		wr_reg(12'h123, 16'hffff);
		rd_chk(`IIB_ADDR_MPX, 16'h0fff);
		rd_chk(`IIB_ADDR_LVL, 16'h80ff);
		rd_chk(`IIB_ADDR_CTRL, 16'h000f);
		rd_chk(12'h123, 16'h0000);
		$display("test 0 done");
		wr_reg(`IIB_ADDR_CTRL, 16'h0000);
		for (int d = 0; d < 4; d++) begin
			wr_reg(`IIB_ADDR_MPX, 16'(d << 9));
			// absorbs a strobe that may have passed during the write
			feed(16'h0000, 8'h00, mu, o);
			for (int k = 0; k < 12; k++) begin
				hist[k] = 16'((d + 1) * 256 + k * 16 + 16);
				feed(hist[k], 8'h00, mu, o);
				if (k >= d + 2)
					chk_word(o, hist[k - d - 2]);
			end
		end
		$display("delay test done");
		run_case(16'h1, 16'h0, 16'h0, 16'h0, 16'h12c, 8'h0, 1, -1, 0);
		run_case(16'h5, 16'h1c0, 16'h0, 16'h0, 16'h12c, 8'h0, 8, -1, 1);
		run_case(16'h1, 16'h800, 16'h0, 16'h0, 16'h12c, 8'h0, 0, -1, 0);
		run_case(16'h1, 16'h800, 16'h0, 16'h0, 16'h258, 8'h0, 1, -1, 0);
		run_case(16'h1, 16'h1, 16'h0, 16'h0, 16'h12c, 8'h0, 0, -1, 0);
		run_case(16'h1, 16'h1, 16'h0, 16'h0, 16'h258, 8'h0, 1, -1, 0);
		run_case(16'h1, 16'h38, 16'h0, 16'h0, 16'h12c, 8'h0, 0, -1, 0);
		run_case(16'h1, 16'h8, 16'h0, 16'h0, 16'h12c, 8'h0, 1, -1, 0);
		run_case(16'h2, 16'h0, 16'h1, 16'h0, 16'h12c, 8'h0, 0, -1, 0);
		run_case(16'h3, 16'h0, 16'h1, 16'h0, 16'h12c, 8'h0, 1, -1, 0);
		run_case(16'h1, 16'h0, 16'h1, 16'h0, 16'h0, 8'h64, 0, -1, 0);
		run_case(16'h2, 16'h0, 16'h1, 16'h0, 16'h0, 8'h64, 1, 6, 0);
		run_case(16'h2, 16'h0, 16'hc1, 16'h0, 16'h0, 8'h64, 4, 6, 0);
		run_case(16'h2, 16'h0, 16'h0, 16'h0, 16'h0, 8'h64, 0, -1, 0);
		run_case(16'h2, 16'h0, 16'hf, 16'h0, 16'h0, 8'h64, 1, 6, 0);
		run_case(16'h2, 16'h0, 16'hf, 16'h0, 16'h0, 8'h3c, 0, -1, 0);
		run_case(16'h2, 16'h0, 16'h11, 16'h0, 16'h0, 8'h64, 1, 5, 0);
		run_case(16'h2, 16'h0, 16'h21, 16'h0, 16'h0, 8'h64, 1, 7, 0);
		run_case(16'h2, 16'h0, 16'h31, 16'h0, 16'h0, 8'h64, 1, 8, 0);
		run_case(16'h2, 16'h600, 16'h1, 16'h0, 16'h0, 8'h64, 1, 9, 0);
		run_case(16'ha, 16'h0, 16'h1, 16'h0, 16'h0, 8'h64, 0, -1, 0);
		run_case(16'h1, 16'h0, 16'h0, 16'h7800, 16'h7c00, 8'h0, 1, -1, 0);
		run_case(16'h1, 16'h0, 16'h8000, 16'h7800, 16'h7c00, 8'h0, 0, -1, 0);
		give_verdict();
	end
endmodule
